// >>> logic/spfd_core.sv
/*
 * Master frame engine of the sync serial port: SPI modes of either clock polarity,
 * half-duplex command format, transmit and receive FIFOs and DMA requests.
 * Assumes configuration inputs are steady while the port is enabled.
 */
module spfd_core (
    input  wire logic                       i_clk,
    input  wire logic                       i_rst_n,
    input  wire logic                       i_enable,
    input  wire logic                       i_master,
    input  wire logic                       i_cmd_format,
    input  wire logic                       i_clock_polarity_bit,
    input  wire logic                       i_clock_phase_bit,
    input  wire logic [3:0]                 i_data_size,
    input  wire logic                       i_tx_wr,
    input  wire logic [spfd_pkg::DATA_W-1:0] i_tx_data,
    input  wire logic                       i_rx_rd,
    input  wire logic                       i_rx_dma_enable,
    input  wire logic                       i_tx_dma_enable,
    input  wire logic                       i_dma_done,
    input  wire logic                       i_serial_rx_line,
    output logic [spfd_pkg::DATA_W-1:0]     o_rx_data,
    output logic                            o_rx_empty,
    output logic                            o_tx_full,
    output logic                            o_rx_dma_single,
    output logic                            o_rx_dma_burst,
    output logic                            o_tx_dma_single,
    output logic                            o_tx_dma_burst,
    output logic                            o_irq,
    output logic                            o_serial_clock_pin,
    output logic                            o_serial_clock_oe,
    output logic                            o_frame_select_pin,
    output logic                            o_serial_tx_line,
    output logic                            o_serial_tx_oe
);
    import spfd_pkg::*;

    // ==========================================================
    // Declarations.
    spfd_state_type     state;
    logic [HALF_W-1:0]  half_cnt;
    logic               tick;
    logic               cmd_r;
    logic               pol_r;
    logic               pha_r;
    logic [3:0]         last_r;
    logic [3:0]         size_in;
    logic [4:0]         bit_cnt;
    logic               reload;
    logic               tail_cnt;
    logic [DATA_W-1:0]  shift_tx;
    logic [DATA_W-1:0]  shift_rx;
    logic [DATA_W-1:0]  rx_word;
    logic [DATA_W-1:0]  load_val;
    logic               rx_meta;
    logic               rx_s;
    logic               idle_lvl;
    logic               cap_lvl;
    logic               cap;
    logic               launch;
    logic               last_bit;
    logic               start;
    logic               more;
    logic               tail_end;
    logic               gap_end;
    logic               tx_pop;
    logic               tx_push;
    logic               rx_push;
    logic               rx_pop;
    logic [DATA_W-1:0]  tx_mem [FIFO_DEPTH];
    logic [DATA_W-1:0]  rx_mem [FIFO_DEPTH];
    logic [PTR_W-1:0]   tx_wr;
    logic [PTR_W-1:0]   tx_rd;
    logic [PTR_W-1:0]   rx_wr;
    logic [PTR_W-1:0]   rx_rd;
    logic [CNT_W-1:0]   tx_count;
    logic [CNT_W-1:0]   rx_count;
    logic [CNT_W-1:0]   next_tx_count;
    logic [CNT_W-1:0]   next_rx_count;
    logic [CNT_W-1:0]   next_tx_free;

    // ==========================================================
    // Receive line synchroniser.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rx_meta <= 1'b0;
            rx_s    <= 1'b0;
        end else begin
            rx_meta <= i_serial_rx_line;
            rx_s    <= rx_meta;
        end
    end

    // ==========================================================
    // Frame decisions.
    function automatic logic [DATA_W-1:0] spfd_align(input logic [DATA_W-1:0] w, input logic cmd,
                                                     input logic [3:0] last);
        if (cmd) begin
            return {w[CTRL_W-1:0], {(DATA_W - CTRL_W){1'b0}}};
        end
        return w << (4'hf - last);
    endfunction : spfd_align

    always_comb begin
        size_in  = (i_data_size < SIZE_MIN) ? SIZE_MIN : i_data_size;
        tick     = (state != ST_IDLE) && (half_cnt == HALF_LAST);
        idle_lvl = cmd_r ? 1'b0 : pol_r;
        cap_lvl  = cmd_r | (pha_r ^ ~pol_r);
        cap      = tick && (state == ST_XFER) && (~o_serial_clock_pin == cap_lvl);
        launch   = tick && (state == ST_XFER) && (~o_serial_clock_pin != cap_lvl);
        last_bit = cmd_r ? (bit_cnt == RESP_FIRST + {1'b0, last_r}) : (bit_cnt == {1'b0, last_r});
        more     = i_enable && (tx_count != 4'h0);
        start    = (state == ST_IDLE) && i_master && more;
        tail_end = tick && (state == ST_TAIL) && tail_cnt;
        gap_end  = tick && (state == ST_GAP) && tail_cnt;
        tx_pop   = start || (launch && reload) || gap_end;
        rx_word  = cmd_r ? shift_rx : {shift_rx[DATA_W-2:0], rx_s};
        rx_push  = (cap && last_bit && !cmd_r) || (cmd_r && ((launch && reload) || tail_end));
        load_val = (state == ST_IDLE) ? spfd_align(tx_mem[tx_rd], i_cmd_format, size_in)
                                      : spfd_align(tx_mem[tx_rd], cmd_r, last_r);
    end

    // ==========================================================
    // Frame engine.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state              <= ST_IDLE;
            half_cnt           <= '0;
            cmd_r              <= 1'b0;
            pol_r              <= 1'b1;
            pha_r              <= 1'b0;
            last_r             <= SIZE_MIN;
            bit_cnt            <= '0;
            reload             <= 1'b0;
            tail_cnt           <= 1'b0;
            shift_tx           <= '0;
            shift_rx           <= '0;
            o_serial_clock_pin <= 1'b1;
            o_frame_select_pin <= 1'b1;
            o_serial_tx_line   <= 1'b0;
            o_serial_tx_oe     <= 1'b0;
        end else begin
            half_cnt <= (state == ST_IDLE || tick) ? '0 : half_cnt + 3'h1;
            case (state)
                ST_IDLE: begin
                    o_serial_clock_pin <= i_cmd_format ? 1'b0 : i_clock_polarity_bit;
                    if (start) begin
                        cmd_r              <= i_cmd_format;
                        pol_r              <= i_clock_polarity_bit;
                        pha_r              <= i_clock_phase_bit;
                        last_r             <= size_in;
                        o_frame_select_pin <= 1'b0;
                        o_serial_tx_oe     <= 1'b1;
                        shift_tx           <= load_val;
                        shift_rx           <= '0;
                        bit_cnt            <= '0;
                        reload             <= 1'b0;
                        o_serial_tx_line   <= i_cmd_format ? load_val[DATA_W-1] : 1'b0;
                        state              <= i_cmd_format ? ST_XFER : ST_SETUP;
                    end
                end
                ST_SETUP: begin
                    if (tick) begin
                        o_serial_tx_line <= shift_tx[DATA_W-1];
                        if (pha_r) begin
                            o_serial_clock_pin <= ~o_serial_clock_pin;
                        end
                        state <= ST_XFER;
                    end
                end
                ST_XFER: begin
                    if (tick) begin
                        o_serial_clock_pin <= ~o_serial_clock_pin;
                        if (cap) begin
                            bit_cnt <= bit_cnt + 5'h01;
                            if (!cmd_r || bit_cnt >= RESP_FIRST) begin
                                shift_rx <= {shift_rx[DATA_W-2:0], rx_s};
                            end
                            if (last_bit) begin
                                reload <= more && (cmd_r || pha_r);
                                if (!(more && (cmd_r || pha_r))) begin
                                    state    <= ST_TAIL;
                                    tail_cnt <= 1'b0;
                                end
                            end
                        end else if (reload) begin
                            reload           <= 1'b0;
                            shift_tx         <= load_val;
                            o_serial_tx_line <= load_val[DATA_W-1];
                            bit_cnt          <= '0;
                            shift_rx         <= '0;
                        end else if (!cmd_r || bit_cnt < CTRL_BITS) begin
                            shift_tx         <= shift_tx << 1;
                            o_serial_tx_line <= shift_tx[DATA_W-2];
                        end else begin
                            o_serial_tx_line <= 1'b0;
                        end
                    end
                end
                ST_TAIL: begin
                    if (tick) begin
                        o_serial_clock_pin <= idle_lvl;
                        tail_cnt           <= 1'b1;
                        if (tail_cnt) begin
                            o_frame_select_pin <= 1'b1;
                            tail_cnt           <= 1'b0;
                            if (!cmd_r && !pha_r && more) begin
                                state <= ST_GAP;
                            end else begin
                                state            <= ST_IDLE;
                                o_serial_tx_oe   <= 1'b0;
                                o_serial_tx_line <= 1'b0;
                            end
                        end
                    end
                end
                ST_GAP: begin
                    if (tick) begin
                        tail_cnt <= 1'b1;
                        if (tail_cnt) begin
                            o_frame_select_pin <= 1'b0;
                            tail_cnt           <= 1'b0;
                            shift_tx           <= load_val;
                            shift_rx           <= '0;
                            bit_cnt            <= '0;
                            state              <= ST_SETUP;
                        end
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // Clock pad ownership.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_serial_clock_oe <= 1'b0;
        end else begin
            o_serial_clock_oe <= i_master;
        end
    end

    // ==========================================================
    // FIFOs.
    always_comb begin
        tx_push       = i_tx_wr && (tx_count != FIFO_DEPTH);
        rx_pop        = i_rx_rd && (rx_count != 4'h0);
        next_tx_count = tx_count + {3'h0, tx_push} - {3'h0, tx_pop};
        next_rx_count = rx_count + {3'h0, rx_push && (rx_count != FIFO_DEPTH)} - {3'h0, rx_pop};
        next_tx_free  = FIFO_DEPTH - next_tx_count;
    end

    always_ff @(posedge i_clk) begin
        if (tx_push) begin
            tx_mem[tx_wr] <= i_tx_data;
        end
        if (rx_push && (rx_count != FIFO_DEPTH)) begin
            rx_mem[rx_wr] <= rx_word;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            tx_wr     <= '0;
            tx_rd     <= '0;
            rx_wr     <= '0;
            rx_rd     <= '0;
            tx_count  <= '0;
            rx_count  <= '0;
            o_rx_data <= '0;
        end else begin
            tx_wr    <= tx_wr + PTR_W'(tx_push);
            tx_rd    <= tx_rd + PTR_W'(tx_pop);
            rx_wr    <= rx_wr + PTR_W'(rx_push && (rx_count != FIFO_DEPTH));
            rx_rd    <= rx_rd + PTR_W'(rx_pop);
            tx_count <= next_tx_count;
            rx_count <= next_rx_count;
            if (rx_pop) begin
                o_rx_data <= rx_mem[rx_rd];
            end
        end
    end

    // ==========================================================
    // Status, DMA requests and completion interrupt.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rx_empty      <= 1'b1;
            o_tx_full       <= 1'b0;
            o_rx_dma_single <= 1'b0;
            o_rx_dma_burst  <= 1'b0;
            o_tx_dma_single <= 1'b0;
            o_tx_dma_burst  <= 1'b0;
            o_irq           <= 1'b0;
        end else begin
            o_rx_empty      <= (next_rx_count == 4'h0);
            o_tx_full       <= (next_tx_count == FIFO_DEPTH);
            o_rx_dma_single <= i_rx_dma_enable && (next_rx_count != 4'h0);
            o_rx_dma_burst  <= i_rx_dma_enable && (next_rx_count >= BURST_LEVEL);
            o_tx_dma_single <= i_tx_dma_enable && (next_tx_free != 4'h0);
            o_tx_dma_burst  <= i_tx_dma_enable && (next_tx_free >= BURST_LEVEL);
            o_irq           <= i_dma_done && (i_rx_dma_enable || i_tx_dma_enable);
        end
    end

    // ==========================================================
    // Assertions.
    sequence s_spi_start;
        (state == ST_IDLE) && start && !i_cmd_format;
    endsequence
    sequence s_setup_half;
        (state == ST_SETUP) [*4] ##1 (state == ST_XFER);
    endsequence

    a_idle_pins: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (state == ST_IDLE) |-> o_frame_select_pin && !o_serial_tx_line && !o_serial_tx_oe)
        else $error("idle frame select or transmit line wrong");
    a_spi_setup_half: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        s_spi_start |=> !o_frame_select_pin && o_serial_tx_oe ##0 s_setup_half)
        else $error("setup half period wrong");
    a_ph0_no_edge: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (state == ST_SETUP && tick && !pha_r) |=> $stable(o_serial_clock_pin)
            && (o_serial_tx_line == $past(shift_tx[DATA_W-1])))
        else $error("phase zero setup moved the clock");
    a_ph1_first_edge: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (state == ST_SETUP && tick && pha_r) |=> $changed(o_serial_clock_pin))
        else $error("phase one first edge missing");
    a_tail_release: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        $rose(state == ST_TAIL) |-> !o_frame_select_pin [*8] ##1 o_frame_select_pin)
        else $error("frame select not released one period after last capture");
    a_gap_pulse: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        $rose(state == ST_GAP) |-> o_frame_select_pin [*8] ##1 !o_frame_select_pin)
        else $error("gap pulse wrong");
    a_ph1_hold: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (state == ST_XFER && (pha_r || cmd_r)) |-> !o_frame_select_pin)
        else $error("frame select rose inside a held frame");
    a_ctrl_no_rx: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (cap && cmd_r && bit_cnt < RESP_FIRST) |=> $stable(shift_rx))
        else $error("data received during control word");
    a_hd_msb: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        ((state == ST_IDLE) && start && i_cmd_format) |=> !o_frame_select_pin
            && (o_serial_tx_line == $past(i_tx_data[7], 1) || o_serial_tx_line == shift_tx[DATA_W-1]))
        else $error("control msb not driven at frame start");
    a_hd_rise_cap: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (cap && cmd_r) |=> o_serial_clock_pin)
        else $error("response latched on wrong edge");
    a_hd_cont_push: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (launch && reload && cmd_r) |-> rx_push && o_serial_clock_pin && !o_frame_select_pin)
        else $error("continuous response not stored on falling edge");
    a_rx_dma: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        ##1 o_rx_dma_burst |-> o_rx_dma_single && (rx_count >= BURST_LEVEL) && $past(i_rx_dma_enable))
        else $error("receive burst request without four entries");
    a_tx_dma: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        o_tx_dma_single |-> (tx_count != FIFO_DEPTH) && !o_tx_full)
        else $error("transmit request with full FIFO");
    a_dma_gate: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (!i_tx_dma_enable && !i_rx_dma_enable) |=> !o_tx_dma_single && !o_tx_dma_burst
            && !o_rx_dma_single && !o_rx_dma_burst)
        else $error("DMA request while disabled");
    a_dma_irq: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_dma_done && i_tx_dma_enable) |=> o_irq)
        else $error("DMA completion not signalled");
endmodule : spfd_core

// >>> shared/spfd_pkg.sv
/*
 * Constants, state type and timing counts for the serial port frame engine.
 * Assumes a 200 MHz system clock and that the port runs as bus master.
 */
package spfd_pkg;
    // ==========================================================
    // Widths and depths.
    localparam int          DATA_W      = 16;
    localparam int          PTR_W       = 3;
    localparam int          CNT_W       = 4;
    localparam logic [3:0]  FIFO_DEPTH  = 4'h8;
    localparam logic [3:0]  BURST_LEVEL = 4'h4;
    localparam logic [3:0]  SIZE_MIN    = 4'h3;
    localparam logic [4:0]  CTRL_BITS   = 5'h08;
    localparam logic [4:0]  RESP_FIRST  = 5'h09;
    localparam int          CTRL_W      = 8;
    // ==========================================================
    // Serial clock timing.
    localparam int          CLK_MHZ     = 200;
    localparam int          SCK_HALF_NS = 20;
    localparam int          HALF_CYCLES = (SCK_HALF_NS * CLK_MHZ + 999) / 1000;
    localparam int          HALF_W      = 3;
    localparam logic [2:0]  HALF_LAST   = 3'(HALF_CYCLES - 1);
    // ==========================================================
    // Frame engine states.
    typedef enum logic [4:0] {
        ST_IDLE  = 5'h01,
        ST_SETUP = 5'h02,
        ST_XFER  = 5'h04,
        ST_TAIL  = 5'h08,
        ST_GAP   = 5'h10
    } spfd_state_type;
endpackage : spfd_pkg

// >>> verif/spfd_slave_model.sv
/* Behavioural off-chip serial slave for the frame engine bench.
   Assumes a master-driven clock, polarity one in SPI and a fixed response word. */
module spfd_slave_model (
    input  wire logic        i_sclk,
    input  wire logic        i_fss_n,
    input  wire logic        i_tx,
    input  wire logic        i_cmd,
    input  wire logic        i_cpha,
    input  wire logic [3:0]  i_size,
    input  wire logic [15:0] i_resp,
    output logic             o_rx,
    output logic [15:0]      o_got
);
    timeunit 1ns;
    timeprecision 100ps;
    int bit_i;
    int n_edge;
    initial o_rx = 1'b0;
    // ==========================================================
    // Frame start, shifting and release.
    always @(negedge i_fss_n) begin
        bit_i = i_size;
        n_edge = 0;
        o_got = '0;
        if (!i_cmd && !i_cpha) begin
            o_rx = i_resp[bit_i];
            bit_i--;
        end
    end
    always @(i_sclk) begin
        if (!i_fss_n) begin
            n_edge++;
            if (i_cmd ? (i_sclk && n_edge <= 15) : (i_sclk == i_cpha)) begin
                o_got = {o_got[14:0], i_tx};
            end else if (i_cmd ? (!i_sclk && n_edge >= 18) : 1'b1) begin
                o_rx = (bit_i >= 0) ? i_resp[bit_i] : ~o_rx;
                bit_i--;
            end
        end
    end
    always @(posedge i_fss_n) o_rx = ~o_rx;
endmodule : spfd_slave_model

// >>> verif/spfd_core_tb.sv
/* Self-checking bench for the serial frame engine with a behavioural slave.
   Assumes the engine runs as master with a four-cycle half serial period. */
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin mismatches++; \
    $display("mismatch %s exp %h got %h", nm, e, g); end end
module spfd_core_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import spfd_pkg::*;
    logic              clk, rst_n, en, master, cmd, cpha, wr, rd, rx_dma, tx_dma, done;
    logic [3:0]        size;
    logic [DATA_W-1:0] wdata, resp, rdata, got;
    logic              rx_ln, empty, full, rs, rb, ts, tb, irq, sck, sck_oe, fss_n, txl, txoe;
    int                mismatches, n_tests, falls;
    spfd_core dut_u (.i_clk(clk), .i_rst_n(rst_n), .i_enable(en), .i_master(master), .i_cmd_format(cmd),
        .i_clock_polarity_bit(1'b1), .i_clock_phase_bit(cpha), .i_data_size(size), .i_tx_wr(wr),
        .i_tx_data(wdata), .i_rx_rd(rd), .i_rx_dma_enable(rx_dma), .i_tx_dma_enable(tx_dma),
        .i_dma_done(done), .i_serial_rx_line(rx_ln), .o_rx_data(rdata), .o_rx_empty(empty),
        .o_tx_full(full), .o_rx_dma_single(rs), .o_rx_dma_burst(rb), .o_tx_dma_single(ts),
        .o_tx_dma_burst(tb), .o_irq(irq), .o_serial_clock_pin(sck), .o_serial_clock_oe(sck_oe),
        .o_frame_select_pin(fss_n), .o_serial_tx_line(txl), .o_serial_tx_oe(txoe));
    spfd_slave_model slave_u (.i_sclk(sck), .i_fss_n(fss_n), .i_tx(txl), .i_cmd(cmd), .i_cpha(cpha),
        .i_size(size), .i_resp(resp), .o_rx(rx_ln), .o_got(got));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(negedge fss_n) falls++;
    // ==========================================================
    // Bench tasks and expectations.
    function automatic logic [15:0] fit(input logic [15:0] w, input logic [3:0] s);
        return w & 16'((17'h1 << (5'(s) + 5'h1)) - 17'h1);
    endfunction : fit
    task automatic tick(input int n = 1);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    task automatic push(input logic [15:0] d);
        wr = 1'b1;
        wdata = d;
        tick();
        wr = 1'b0;
    endtask : push
    task automatic pop_chk(input logic [15:0] e);
        rd = 1'b1;
        tick();
        rd = 1'b0;
        tick();
        `CHK("rx_word", e, rdata)
    endtask : pop_chk
    task automatic wait_frames(input int n);
        for (int i = 0; i < 4000 && falls < n; i++) tick();
        tick(300);
    endtask : wait_frames
    task automatic single(input logic c, input logic p);
        logic [15:0] w;
        en = 1'b0;
        cmd = c;
        cpha = p;
        size = 4'($urandom_range(15, 3));
        resp = 16'($urandom);
        w = 16'($urandom);
        tick();
        falls = 0;
        push(w);
        en = 1'b1;
        wait_frames(1);
        `CHK("sent", c ? {8'h00, w[7:0]} : fit(w, size), got)
        `CHK("idle_sck", !c, sck)
        `CHK("idle_fss", 1'b1, fss_n)
        `CHK("idle_tx", 1'b0, txl)
        `CHK("idle_txoe", 1'b0, txoe)
        `CHK("rx_held", 1'b0, empty)
        pop_chk(fit(resp, size));
        `CHK("rx_empty", 1'b1, empty)
        $display("test single cmd=%0d phase=%0d done", c, p);
    endtask : single
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : finish_test
    // ==========================================================
    // Main sequence and watchdog.
    initial begin
        {en, cmd, cpha, wr, rd, rx_dma, tx_dma, done} = '0;
        {master, rst_n, size, wdata, resp} = {1'b1, 1'b0, 4'h7, 32'h0};
        void'($urandom(32'h4565));
        tick(5);
        rst_n = 1'b1;
        master = 1'b0;
        tick(3);
        `CHK("slave_pad", 1'b0, sck_oe)
        master = 1'b1;
        tick(2);
        `CHK("master_pad", 1'b1, sck_oe)
        for (int m = 0; m < 4; m++) single(m[1], m[0]);
        {en, cmd, cpha, tx_dma, rx_dma} = 5'h03;
        falls = 0;
        for (int i = 0; i < 6; i++) push(16'($urandom));
        tick(2);
        `CHK("tx_burst", 1'b0, tb)
        `CHK("tx_single", 1'b1, ts)
        push(16'h1234);
        push(16'h00ff);
        tick(2);
        `CHK("tx_full_single", 1'b0, ts)
        `CHK("tx_full", 1'b1, full)
        en = 1'b1;
        wait_frames(8);
        `CHK("frames_b2b0", 8, falls)
        `CHK("rx_burst", 1'b1, rb)
        tx_dma = 1'b0;
        tick(2);
        `CHK("tx_gated", 1'b0, ts)
        for (int i = 0; i < 5; i++) pop_chk(fit(resp, size));
        `CHK("rx_burst_drop", 1'b0, rb)
        `CHK("rx_single", 1'b1, rs)
        for (int i = 0; i < 3; i++) pop_chk(fit(resp, size));
        `CHK("rx_single_drop", 1'b0, rs)
        {en, cpha} = 2'h1;
        falls = 0;
        push(16'($urandom));
        push(16'($urandom));
        en = 1'b1;
        wait_frames(1);
        `CHK("frames_b2b1", 1, falls)
        done = 1'b1;
        tick();
        done = 1'b0;
        `CHK("irq_on", 1'b1, irq)
        rx_dma = 1'b0;
        done = 1'b1;
        tick();
        done = 1'b0;
        `CHK("irq_gated", 1'b0, irq)
        $display("test back_to_back and dma done");
        finish_test();
    end
    initial begin
        #200000;
        mismatches++;
        finish_test();
    end
endmodule : spfd_core_tb
